// ==== pkg/rml_pkg.sv ====
package rml_pkg;
	localparam int CLK_HZ = 250_000_000;
	localparam int FIFO_DEPTH = 8;
	localparam int GAP_BITS = 39;
	localparam int REPLY_START_MAX_MS = 100;
	localparam int REPLY_START_MAX_CYC = CLK_HZ / 1000 * REPLY_START_MAX_MS;
	localparam int RELEASE_MAX_MS = 2;
	localparam int RELEASE_MAX_CYC = CLK_HZ / 1000 * RELEASE_MAX_MS;
	localparam logic [3:0] CHAR_BITS_PAR = 4'hb;
	localparam logic [3:0] CHAR_BITS_NOPAR = 4'ha;
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h2;
	localparam logic [7:0] BCAST_ADDR = 8'h00;
	localparam logic [7:0] NODE_MIN = 8'h01;
	localparam logic [7:0] NODE_MAX = 8'hf7;
	localparam logic [7:0] FN_READ = 8'h03;
	localparam logic [7:0] FN_COIL = 8'h05;
	localparam logic [7:0] FN_WRITE = 8'h06;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_FUNC = 8'h01;
	localparam logic [7:0] EXC_VALUE = 8'h03;
	localparam logic [7:0] EXC_FAIL = 8'h04;
	localparam logic [15:0] COIL_ON = 16'hff00;
	localparam logic [15:0] COIL_OFF = 16'h0000;
	localparam logic [15:0] READ_MAX = 16'h007d;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [15:0] CRC_GOOD = 16'h0000;
	localparam logic [3:0] REQ_LEN = 4'h8;
	localparam logic [3:0] MIN_LEN = 4'h4;

	typedef struct packed {
		logic [2:0] link_rate_select;
		logic [1:0] parity_select;
		logic [7:0] node_addr;
	} rml_cfg_t;

	typedef struct packed {
		logic write;
		logic coil;
		logic broadcast;
		logic [15:0] reg_addr;
		logic [15:0] value;
	} rml_req_t;

	function automatic logic [17:0] rate_div(input int clk_hz,
		input logic [2:0] sel);
		case (sel)
			3'h0: return 18'(clk_hz / 1200);
			3'h1: return 18'(clk_hz / 2400);
			3'h2: return 18'(clk_hz / 4800);
			3'h3: return 18'(clk_hz / 9600);
			3'h4: return 18'(clk_hz / 19200);
			3'h5: return 18'(clk_hz / 38400);
			3'h6: return 18'(clk_hz / 57600);
			default: return 18'(clk_hz / 115200);
		endcase
	endfunction

	function automatic logic parity_bit(input logic [7:0] d,
		input logic [1:0] sel);
		return (sel == PAR_ODD) ? ~^d : ^d;
	endfunction

	function automatic logic [15:0] crc16_step(input logic [15:0] crc,
		input logic [7:0] d);
		logic [15:0] c;
		c = crc ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		return c;
	endfunction
endpackage

// ==== rtl/rml_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
module rml_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
)
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	import rml_pkg::*;
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic wr;
	logic rd;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign wr = in_valid && in_ready;
	assign rd = out_valid && out_ready;

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (wr)
				wr_ptr <= ptr_inc(wr_ptr);
			if (rd)
				rd_ptr <= ptr_inc(rd_ptr);
			if (wr && !rd)
				count <= count + 1'b1;
			else if (rd && !wr)
				count <= count - 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (wr)
			mem[wr_ptr] <= in_data;
	end
endmodule
`default_nettype wire

// ==== rtl/rml_tx.sv ====
`timescale 1ns/100ps
`default_nettype none
module rml_tx
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [17:0] div,
	input wire logic [1:0] parity_select,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [7:0] in_data,
	output logic line_out,
	output logic line_oe,
	output logic busy
);
	import rml_pkg::*;

	logic [10:0] sh;
	logic [3:0] nbits;
	logic [17:0] cnt;
	logic last;
	logic [10:0] next_frame;

	// Without parity the stop bit is simply sent one slot early.
	assign next_frame = (parity_select == PAR_NONE) ?
		{2'b11, in_data, 1'b0} :
		{1'b1, parity_bit(in_data, parity_select), in_data, 1'b0};
	assign last = busy && (cnt == '0) && (nbits == 4'h1);
	// Back-to-back loading keeps the driver on between bytes of a reply.
	assign in_ready = !busy || last;
	assign line_out = sh[0];
	assign line_oe = busy;

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			sh <= '1;
			nbits <= '0;
			cnt <= '0;
			busy <= 1'b0;
		end
		else if (in_valid && in_ready)
		begin
			sh <= next_frame;
			nbits <= (parity_select == PAR_NONE) ? CHAR_BITS_NOPAR :
				CHAR_BITS_PAR;
			cnt <= div - 18'h0_0001;
			busy <= 1'b1;
		end
		else if (busy)
		begin
			if (cnt != '0)
				cnt <= cnt - 18'h0_0001;
			else
			begin
				sh <= {1'b1, sh[10:1]};
				nbits <= nbits - 4'h1;
				cnt <= div - 18'h0_0001;
				if (nbits == 4'h1)
					busy <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ==== rtl/rml_link.sv ====
`timescale 1ns/100ps
`default_nettype none
// Function
// - Acts only as slave, never starts transfers.
// - Own-address requests are processed and answered.
// - Broadcast requests are executed without reply; broadcast reads are dropped unexecuted.
// - Slave address zero marks a broadcast.
// - One master, 31 slaves, addresses to 247.
// - Own node address limited to 1..247.
// - Driver released within 2 ms after reply.
// - Reply starts within 100 ms of request.
// - Bit rate 1200 to 115200, both ends match.
// - Exactly eight selectable rates, 1.2 to 115.2k.
// - Eight data bits, optional parity, one stop.
// - Rate, parity, node address are user settings.
// - Function codes 03, 06 and 05 supported.
module rml_link
#(
	parameter int CLK_HZ = rml_pkg::CLK_HZ,
	parameter int FIFO_DEPTH = rml_pkg::FIFO_DEPTH,
	parameter int ACCESS_MAX_CYC = rml_pkg::REPLY_START_MAX_CYC / 2,
	parameter int REPLY_START_MAX_CYC = rml_pkg::REPLY_START_MAX_CYC,
	parameter int RELEASE_MAX_CYC = rml_pkg::RELEASE_MAX_CYC
)
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire rml_pkg::rml_cfg_t link_cfg,
	input wire logic bus_in,
	output logic bus_out,
	output logic bus_oe,
	output var rml_pkg::rml_req_t app_req,
	output logic app_req_valid,
	input wire logic app_ack,
	input wire logic [15:0] app_rdata
);
	import rml_pkg::*;

	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
		rml_rx_t;
	typedef enum logic [2:0] {S_IDLE, S_ACCESS, S_EMIT, S_HI, S_LO, S_CRC_LO,
		S_CRC_HI} rml_rsp_t;

	rml_cfg_t cfg;
	logic [17:0] div;
	logic node_ok;
	rml_rx_t rx_state;
	logic [17:0] rx_cnt;
	logic [2:0] rx_idx;
	logic [7:0] rx_sh;
	logic rx_par;
	logic byte_done;
	logic byte_err;
	logic [23:0] gap_cnt;
	logic [23:0] gap_lim;
	logic frame_end;
	logic [7:0] fbuf [8];
	logic [3:0] flen;
	logic [15:0] fcrc;
	logic fbad;
	logic frame_ok;
	logic is_bcast;
	logic is_mine;
	logic len8;
	logic fn_known;
	logic val_ok;
	logic [7:0] exc_code;
	logic accept;
	logic [15:0] f_val;
	rml_rsp_t rsp_state;
	logic [7:0] hdr [6];
	logic [2:0] hidx;
	logic [2:0] hlen;
	logic [6:0] words;
	logic [15:0] word;
	logic [15:0] rcrc;
	logic [31:0] acc_cnt;
	logic push;
	logic [7:0] push_byte;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [7:0] fifo_out_data;
	logic tx_busy;
	logic job_read;

	assign div = rate_div(CLK_HZ, cfg.link_rate_select);
	assign node_ok = (cfg.node_addr >= NODE_MIN) &&
		(cfg.node_addr <= NODE_MAX);

	// Settings are taken only on a quiet bus so no character is split.
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			cfg <= '0;
		else if (rx_state == RX_IDLE && rsp_state == S_IDLE && !tx_busy &&
			flen == '0)
			cfg <= link_cfg;
	end

	always_ff @(posedge ref_clk)
	begin
		byte_done <= 1'b0;
		if (sys_rst)
		begin
			rx_state <= RX_IDLE;
			rx_cnt <= '0;
			rx_idx <= '0;
			rx_sh <= '0;
			rx_par <= 1'b0;
			byte_err <= 1'b0;
			byte_done <= 1'b0;
		end
		else if (rx_state != RX_IDLE && rx_cnt != '0)
			rx_cnt <= rx_cnt - 18'h0_0001;
		else
		begin
			case (rx_state)
				RX_IDLE:
					// Own transmission is not received back on the half-duplex pair.
					if (!tx_busy && !bus_in)
					begin
						rx_state <= RX_START;
						rx_cnt <= {1'b0, div[17:1]};
					end
				RX_START:
				begin
					rx_state <= bus_in ? RX_IDLE : RX_DATA;
					rx_cnt <= div - 18'h0_0001;
					rx_idx <= '0;
				end
				RX_DATA:
				begin
					rx_sh <= {bus_in, rx_sh[7:1]};
					rx_idx <= rx_idx + 3'h1;
					rx_cnt <= div - 18'h0_0001;
					if (rx_idx == 3'h7)
						rx_state <= (cfg.parity_select == PAR_NONE) ? RX_STOP :
							RX_PAR;
				end
				RX_PAR:
				begin
					rx_par <= bus_in;
					rx_cnt <= div - 18'h0_0001;
					rx_state <= RX_STOP;
				end
				RX_STOP:
				begin
					byte_done <= 1'b1;
					byte_err <= !bus_in || (cfg.parity_select != PAR_NONE &&
						rx_par != parity_bit(rx_sh, cfg.parity_select));
					rx_state <= RX_IDLE;
				end
				default:
					rx_state <= RX_IDLE;
			endcase
		end
	end

	// Frames end after about three and a half characters of silence.
	assign gap_lim = 24'(div * GAP_BITS);
	assign frame_end = (rx_state == RX_IDLE) && (flen != '0) &&
		(gap_cnt == gap_lim - 24'h00_0001);

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || byte_done || rx_state != RX_IDLE)
			gap_cnt <= '0;
		else if (gap_cnt != gap_lim)
			gap_cnt <= gap_cnt + 24'h00_0001;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || frame_end)
		begin
			flen <= '0;
			fcrc <= CRC_INIT;
			fbad <= 1'b0;
		end
		else if (byte_done)
		begin
			if (flen < REQ_LEN)
				fbuf[flen[2:0]] <= rx_sh;
			if (flen != 4'hf)
				flen <= flen + 4'h1;
			fcrc <= crc16_step(fcrc, rx_sh);
			fbad <= fbad | byte_err;
		end
	end

	assign f_val = {fbuf[4], fbuf[5]};
	assign frame_ok = !fbad && fcrc == CRC_GOOD && flen >= MIN_LEN;
	assign is_bcast = (fbuf[0] == BCAST_ADDR);
	assign is_mine = node_ok && (fbuf[0] == cfg.node_addr);
	assign len8 = (flen == REQ_LEN);
	assign fn_known = fbuf[1] == FN_READ || fbuf[1] == FN_COIL ||
		fbuf[1] == FN_WRITE;
	assign val_ok = (fbuf[1] == FN_READ) ? (f_val != '0 && f_val <= READ_MAX) :
		(fbuf[1] == FN_COIL) ? (f_val == COIL_ON || f_val == COIL_OFF) : 1'b1;
	assign exc_code = !fn_known ? EXC_FUNC : (!len8 || !val_ok) ? EXC_VALUE :
		EXC_NONE;
	// Frames for other nodes, or arriving while a reply is pending, are dropped.
	assign accept = frame_end && frame_ok && rsp_state == S_IDLE &&
		(is_mine || is_bcast);
	assign job_read = !app_req.write && !app_req.coil;
	assign app_req_valid = (rsp_state == S_ACCESS);
	assign push = fifo_in_ready && (rsp_state == S_EMIT ||
		rsp_state == S_HI || rsp_state == S_LO || rsp_state == S_CRC_LO ||
		rsp_state == S_CRC_HI);

	always_comb
	begin
		case (rsp_state)
			S_EMIT: push_byte = hdr[hidx];
			S_HI: push_byte = word[15:8];
			S_LO: push_byte = word[7:0];
			S_CRC_LO: push_byte = rcrc[7:0];
			S_CRC_HI: push_byte = rcrc[15:8];
			default: push_byte = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			rsp_state <= S_IDLE;
			app_req <= '0;
			hidx <= '0;
			hlen <= '0;
			words <= '0;
			word <= '0;
			rcrc <= CRC_INIT;
			acc_cnt <= '0;
		end
		else
		begin
			if (push && (rsp_state == S_EMIT || rsp_state == S_HI ||
				rsp_state == S_LO))
				rcrc <= crc16_step(rcrc, push_byte);
			case (rsp_state)
				S_IDLE:
					if (accept)
					begin
						for (int i = 0; i < 6; i++)
							hdr[i] <= fbuf[i];
						app_req.write <= (fbuf[1] == FN_WRITE);
						app_req.coil <= (fbuf[1] == FN_COIL);
						app_req.broadcast <= is_bcast;
						app_req.reg_addr <= {fbuf[2], fbuf[3]};
						app_req.value <= f_val;
						rcrc <= CRC_INIT;
						hidx <= '0;
						hlen <= 3'h6;
						words <= '0;
						acc_cnt <= '0;
						if (is_bcast)
							rsp_state <= (exc_code != EXC_NONE ||
								fbuf[1] == FN_READ) ? S_IDLE : S_ACCESS;
						else if (exc_code != EXC_NONE)
						begin
							hdr[1] <= fbuf[1] | EXC_FLAG;
							hdr[2] <= exc_code;
							hlen <= 3'h3;
							rsp_state <= S_EMIT;
						end
						else if (fbuf[1] == FN_READ)
						begin
							hdr[2] <= {f_val[6:0], 1'b0};
							hlen <= 3'h3;
							words <= f_val[6:0];
							rsp_state <= S_EMIT;
						end
						else
							rsp_state <= S_ACCESS;
					end
				S_ACCESS:
				begin
					acc_cnt <= acc_cnt + 32'h0000_0001;
					// A stalled application is cut off so the reply still starts in time.
					if (app_ack || acc_cnt == 32'(ACCESS_MAX_CYC - 1))
					begin
						acc_cnt <= '0;
						word <= app_ack ? app_rdata : 16'h0000;
						if (job_read)
							rsp_state <= S_HI;
						else if (app_req.broadcast)
							rsp_state <= S_IDLE;
						else
						begin
							if (!app_ack)
							begin
								hdr[1] <= hdr[1] | EXC_FLAG;
								hdr[2] <= EXC_FAIL;
								hlen <= 3'h3;
							end
							rsp_state <= S_EMIT;
						end
					end
				end
				S_EMIT:
					if (push)
					begin
						hidx <= hidx + 3'h1;
						if (hidx == hlen - 3'h1)
							rsp_state <= (words != '0) ? S_ACCESS : S_CRC_LO;
					end
				S_HI:
					if (push)
						rsp_state <= S_LO;
				S_LO:
					if (push)
					begin
						words <= words - 7'h01;
						app_req.reg_addr <= app_req.reg_addr + 16'h0001;
						rsp_state <= (words == 7'h01) ? S_CRC_LO : S_ACCESS;
					end
				S_CRC_LO:
					if (push)
						rsp_state <= S_CRC_HI;
				S_CRC_HI:
					if (push)
						rsp_state <= S_IDLE;
				default:
					rsp_state <= S_IDLE;
			endcase
		end
	end

	rml_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(push_byte),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// The driver is enabled only while the serializer holds a reply byte.
	rml_tx u_tx (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.div(div),
		.parity_select(cfg.parity_select),
		.in_valid(fifo_out_valid),
		.in_ready(fifo_out_ready),
		.in_data(fifo_out_data),
		.line_out(bus_out),
		.line_oe(bus_oe),
		.busy(tx_busy)
	);

	logic job_live;
	logic [31:0] wait_cnt;
	logic [31:0] rel_cnt;
	logic [23:0] char_cnt;
	logic [23:0] char_len;

	// A driver still on after one full character frame was never released.
	assign char_len = 24'(div) * ((cfg.parity_select == PAR_NONE) ?
		24'(CHAR_BITS_NOPAR) : 24'(CHAR_BITS_PAR));

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			job_live <= 1'b0;
			wait_cnt <= '0;
			rel_cnt <= '0;
			char_cnt <= '0;
		end
		else
		begin
			if (accept && !is_bcast)
				job_live <= 1'b1;
			else if (rsp_state == S_IDLE && !fifo_out_valid && !tx_busy)
				job_live <= 1'b0;
			wait_cnt <= (job_live && !bus_oe) ? wait_cnt + 32'h0000_0001 : '0;
			if (fifo_out_valid && fifo_out_ready)
				char_cnt <= '0;
			else if (bus_oe && char_cnt != '1)
				char_cnt <= char_cnt + 24'h00_0001;
			rel_cnt <= (bus_oe && char_cnt >= char_len) ?
				rel_cnt + 32'h0000_0001 : '0;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_accept_unicast;
		accept && !is_bcast && (exc_code != EXC_NONE || fbuf[1] == FN_READ);
	endsequence
	sequence s_addr_first;
		rsp_state == S_EMIT && hidx == 3'h0;
	endsequence

	property p_slave_only;
		$rose(bus_oe) |-> job_live;
	endproperty
	a_slave_only: assert property (p_slave_only) else $error("drive w/o job");

	property p_addressed_reply;
		s_accept_unicast |=> s_addr_first ##0 (push_byte == $past(fbuf[0]));
	endproperty
	a_addressed_reply: assert property (p_addressed_reply)
		else $error("addressed request got no reply header");

	property p_bcast_silent;
		accept && is_bcast |=> (rsp_state == S_IDLE ||
			rsp_state == S_ACCESS)[*8];
	endproperty
	a_bcast_silent: assert property (p_bcast_silent)
		else $error("broadcast produced a reply");

	property p_bcast_flag;
		accept && fbuf[0] == BCAST_ADDR |=> app_req.broadcast;
	endproperty
	a_bcast_flag: assert property (p_bcast_flag)
		else $error("address zero not taken as broadcast");

	property p_node_range;
		frame_end && (cfg.node_addr < NODE_MIN || cfg.node_addr > NODE_MAX) &&
			!is_bcast |=> rsp_state == S_IDLE;
	endproperty
	a_node_range: assert property (p_node_range)
		else $error("out of range node address answered");

	property p_release;
		rel_cnt < RELEASE_MAX_CYC;
	endproperty
	a_release: assert property (p_release)
		else $error("driver held after last byte");

	property p_reply_start;
		wait_cnt < REPLY_START_MAX_CYC;
	endproperty
	a_reply_start: assert property (p_reply_start)
		else $error("reply start too late");

	property p_parity_check;
		byte_done && cfg.parity_select != PAR_NONE &&
			rx_par != parity_bit(rx_sh, cfg.parity_select) |-> byte_err;
	endproperty
	a_parity_check: assert property (p_parity_check)
		else $error("parity error not flagged");

	property p_foreign_drop;
		frame_end && !is_mine && !is_bcast |=> rsp_state == S_IDLE [*2];
	endproperty
	a_foreign_drop: assert property (p_foreign_drop)
		else $error("foreign frame answered");

	property p_bad_drop;
		frame_end && fbad |=> rsp_state == S_IDLE;
	endproperty
	a_bad_drop: assert property (p_bad_drop)
		else $error("errored frame answered");
endmodule
`default_nettype wire

// ==== dv/rml_host.sv ====
`timescale 1ns/100ps
`default_nettype none
// Bus master model. It drives only while it sends a request. Outside that
// the bench resolves the wire to bus_out while bus_oe is set, else to its biased idle level.
module rml_host
(
	input wire logic ref_clk,
	input wire logic line,
	input wire logic dev_oe,
	input wire logic [17:0] div,
	input wire logic [1:0] par_sel,
	output logic host_tx,
	output logic host_oe
);
	logic [7:0] rx_q[$];
	int n_bad_char;
	logic [7:0] d;

	initial
	begin
		host_tx = 1'b1;
		host_oe = 1'b0;
		n_bad_char = 0;
	end

	task automatic send_char(input logic [7:0] c, input logic bad_par);
		logic [10:0] bits;
		logic pb;
		int n;
		pb = (^c ^ (par_sel == 2'h2)) ^ bad_par;
		bits = (par_sel == 2'h0) ? {2'b11, c, 1'b0} : {1'b1, pb, c, 1'b0};
		n = (par_sel == 2'h0) ? 10 : 11;
		for (int i = 0; i < n; i++)
		begin
			host_tx <= bits[i];
			repeat (div) @(posedge ref_clk);
		end
	endtask

	// The caller waits for the reply before the next request.
	task automatic send_frame(input logic [7:0] f[$], input int bad_idx);
		@(posedge ref_clk);
		host_oe <= 1'b1;
		foreach (f[i])
			send_char(f[i], i == bad_idx);
		host_oe <= 1'b0;
	endtask

	// Characters are sampled at mid-bit; format faults are counted.
	initial
	forever
	begin
		@(posedge ref_clk);
		if (dev_oe === 1'b1 && line === 1'b0)
		begin
			repeat (div / 2) @(posedge ref_clk);
			for (int i = 0; i < 8; i++)
			begin
				repeat (div) @(posedge ref_clk);
				d[i] = line;
			end
			if (par_sel != 2'h0)
			begin
				repeat (div) @(posedge ref_clk);
				if (line !== (^d ^ (par_sel == 2'h2)))
					n_bad_char++;
			end
			repeat (div) @(posedge ref_clk);
			if (line !== 1'b1)
				n_bad_char++;
			rx_q.push_back(d);
		end
	end
endmodule
`default_nettype wire

// ==== dv/rml_link_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHECK(what, exp, got) \
	begin \
		compares++; \
		if ((exp) !== (got)) \
		begin \
			$display("BAD %s expected %h seen %h", what, exp, got); \
			n_mismatch++; \
		end \
	end
module rml_link_test;
	import rml_pkg::*;
	typedef logic [7:0] rml_bytes_t[$];
	// A nominal slow clock keeps every character in this test to at most 1200 cycles.
	localparam int TB_HZ = 1_152_000;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	rml_cfg_t link_cfg = '0;
	logic bus_in;
	logic bus_out;
	logic bus_oe;
	rml_req_t app_req;
	logic app_req_valid;
	logic app_ack = 1'b0;
	logic [15:0] app_rdata = 16'h0000;
	logic host_tx;
	logic host_oe;
	rml_req_t last_req;
	int n_acc = 0;
	int n_oe = 0;
	int n_mismatch = 0;
	int compares = 0;
	logic [15:0] lfsr = 16'h002a;
	logic [7:0] node;
	logic [17:0] bdiv;
	logic app_mute = 1'b0;

	always #2 ref_clk = ~ref_clk;
	// Failsafe biasing holds the released pair at the idle level.
	assign bus_in = bus_oe ? bus_out : (host_oe ? host_tx : 1'b1);

	rml_link #(.CLK_HZ(TB_HZ), .ACCESS_MAX_CYC(200),
		.REPLY_START_MAX_CYC(1000), .RELEASE_MAX_CYC(10)) dut (
		.ref_clk(ref_clk), .sys_rst(sys_rst),
		.link_cfg(link_cfg), .bus_in(bus_in), .bus_out(bus_out),
		.bus_oe(bus_oe), .app_req(app_req), .app_req_valid(app_req_valid),
		.app_ack(app_ack), .app_rdata(app_rdata));

	rml_host host (.ref_clk(ref_clk), .line(bus_in), .dev_oe(bus_oe),
		.div(bdiv), .par_sel(link_cfg.parity_select),
		.host_tx(host_tx), .host_oe(host_oe));

	// Application side: one-cycle acknowledge a cycle after each request, none while app_mute is set.
	always @(posedge ref_clk)
	begin
		app_ack <= 1'b0;
		if (bus_oe === 1'b1)
			n_oe++;
		if (app_req_valid === 1'b1 && app_ack === 1'b0 && !app_mute)
		begin
			app_ack <= 1'b1;
			last_req <= app_req;
			n_acc++;
		end
	end

	function automatic logic [15:0] next_rand(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [17:0] bench_div(input logic [2:0] sel);
		int rate;
		rate = (sel == 3'h7) ? 115200 : (sel == 3'h6) ? 57600 : 1200 << sel;
		return 18'(TB_HZ / rate);
	endfunction

	assign bdiv = bench_div(link_cfg.link_rate_select);

	function automatic rml_bytes_t seal(input rml_bytes_t f);
		logic [15:0] c;
		c = 16'hffff;
		foreach (f[i])
		begin
			c ^= {8'h00, f[i]};
			for (int b = 0; b < 8; b++)
				c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		end
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
		return f;
	endfunction

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic configure(input logic [2:0] rate, input logic [1:0] par);
		@(posedge ref_clk);
		link_cfg <= '{rate, par, node};
		repeat (10) @(posedge ref_clk);
	endtask

	// An empty expectation means the line must stay undriven throughout.
	task automatic exchange(input rml_bytes_t rq, input int bad_idx,
		input rml_bytes_t ex);
		int lim;
		int oe0;
		lim = (43 + 11 * ex.size()) * int'(bdiv) + 400;
		host.rx_q.delete();
		oe0 = n_oe;
		host.send_frame(seal(rq), bad_idx);
		for (int i = 0; i < lim && (ex.size() == 0 ||
			host.rx_q.size() < ex.size()); i++)
			@(posedge ref_clk);
		`CHECK("reply_len", ex.size(), host.rx_q.size())
		if (host.rx_q.size() < ex.size())
			complete_run();
		foreach (ex[i])
			`CHECK("reply_byte", ex[i], host.rx_q[i])
		`CHECK("char_format", 0, host.n_bad_char)
		if (ex.size() == 0)
			`CHECK("silent_drive", oe0, n_oe)
		else
		begin
			repeat (bdiv) @(posedge ref_clk);
			`CHECK("driver_released", 1'b0, bus_oe)
		end
	endtask

	task automatic check_req(input int acc0, input logic [2:0] kind,
		input logic [15:0] ra, input logic [15:0] v, input logic use_v);
		`CHECK("accesses", acc0 + 1, n_acc)
		`CHECK("req_kind", kind, {last_req.write, last_req.coil,
			last_req.broadcast})
		`CHECK("req_reg", ra, last_req.reg_addr)
		if (use_v)
			`CHECK("req_value", v, last_req.value)
	endtask

	initial
	begin
		rml_bytes_t rq;
		rml_bytes_t ex;
		logic [15:0] ra;
		logic [15:0] v;
		int acc0;
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		lfsr = next_rand(lfsr);
		node = 8'(lfsr % 247 + 1);
		@(posedge ref_clk);
		`CHECK("reset_oe", 1'b0, bus_oe)
		`CHECK("reset_req", 1'b0, app_req_valid)
		lfsr = next_rand(lfsr);
		ra = lfsr;
		lfsr = next_rand(lfsr);
		v = lfsr;
		// Read one register with even parity.
		configure(3'h7, PAR_EVEN);
		app_rdata <= v;
		acc0 = n_acc;
		rq = '{node, FN_READ, ra[15:8], ra[7:0], 8'h00, 8'h01};
		exchange(rq, -1, seal('{node, FN_READ, 8'h02, v[15:8], v[7:0]}));
		check_req(acc0, 3'b000, ra, v, 1'b0);
		// Write one register with odd parity; the reply echoes the request.
		configure(3'h7, PAR_ODD);
		acc0 = n_acc;
		rq = '{node, FN_WRITE, ra[7:0], ra[15:8], v[7:0], v[15:8]};
		exchange(rq, -1, seal(rq));
		check_req(acc0, 3'b100, {ra[7:0], ra[15:8]}, {v[7:0], v[15:8]},
			1'b1);
		// Unknown function code draws an exception reply.
		rq = '{node, 8'h07, ra[15:8], ra[7:0], 8'h00, 8'h01};
		exchange(rq, -1, seal('{node, EXC_FLAG | 8'h07, EXC_FUNC}));
		// A coil value other than on or off draws a value exception.
		rq = '{node, FN_COIL, ra[15:8], ra[7:0], 8'h12, 8'h34};
		exchange(rq, -1, seal('{node, EXC_FLAG | FN_COIL, EXC_VALUE}));
		// A stalled application times out into a failure exception.
		app_mute <= 1'b1;
		acc0 = n_acc;
		rq = '{node, FN_WRITE, ra[15:8], ra[7:0], v[15:8], v[7:0]};
		exchange(rq, -1, seal('{node, EXC_FLAG | FN_WRITE, EXC_FAIL}));
		`CHECK("stall_access", acc0, n_acc)
		`CHECK("req_dropped", 1'b0, app_req_valid)
		app_mute <= 1'b0;
		// Two registers at a lower rate; the reply outgrows the queue.
		configure(3'h6, PAR_EVEN);
		acc0 = n_acc;
		rq = '{node, FN_READ, ra[15:8], ra[7:0], 8'h00, 8'h02};
		ex = seal('{node, FN_READ, 8'h04, v[15:8], v[7:0], v[15:8], v[7:0]});
		exchange(rq, -1, ex);
		`CHECK("read_accesses", acc0 + 2, n_acc)
		`CHECK("read_next_reg", ra + 16'h0001, last_req.reg_addr)
		// Broadcast coil force without parity: executed, never answered.
		configure(3'h3, PAR_NONE);
		acc0 = n_acc;
		ex = {};
		rq = '{BCAST_ADDR, FN_COIL, ra[15:8], ra[7:0], 8'hff, 8'h00};
		exchange(rq, -1, ex);
		check_req(acc0, 3'b011, ra, COIL_ON, 1'b1);
		// Foreign address: ignored.
		configure(3'h7, PAR_EVEN);
		acc0 = n_acc;
		rq = '{(node == NODE_MAX) ? NODE_MIN : node + 8'h01, FN_READ,
			ra[15:8], ra[7:0], 8'h00, 8'h01};
		exchange(rq, -1, ex);
		`CHECK("foreign_access", acc0, n_acc)
		// Parity fault inside an own-address write voids the frame.
		rq = '{node, FN_WRITE, ra[15:8], ra[7:0], v[15:8], v[7:0]};
		exchange(rq, 3, ex);
		`CHECK("fault_access", acc0, n_acc)
		// An own address beyond the top of the range is never answered.
		node = NODE_MAX + 8'h01;
		configure(3'h7, PAR_EVEN);
		acc0 = n_acc;
		rq = '{node, FN_READ, ra[15:8], ra[7:0], 8'h00, 8'h01};
		exchange(rq, -1, ex);
		`CHECK("range_access", acc0, n_acc)
		complete_run();
	end
endmodule
`default_nettype wire
